// ---- rtl/core_clock_divider.v ----
// Purpose: divide the main clock by the baud value into a core tick
// Assumes: baud value of zero acts as one
// Notes: a tick enable, not a derived clock, keeps one clock domain
`timescale 1ns/100ps
module core_clock_divider #(
  parameter WIDTH = 16
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire [WIDTH-1:0] i_divisor,
  output wire o_tick
);
  reg [WIDTH-1:0] count_reg;
  wire wrap;

  // (R17) divide by baud
  assign wrap = (count_reg + {{(WIDTH-1){1'b0}}, 1'b1}) >= i_divisor;
  assign o_tick = wrap;

  // counter restarts on wrap, so a lowered divisor takes effect at once
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (wrap) begin
      count_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ---- rtl/negotiation_pulse.v ----
// Purpose: time the negotiation high pulse from the bit time value
// Assumes: one core tick per core bit clock period
// Notes: pulse length is bit time shifted right by two
`timescale 1ns/100ps
module negotiation_pulse #(
  parameter WIDTH = 16
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_tick,
  input wire i_start,
  input wire [WIDTH-1:0] i_bit_time,
  output wire o_pulse
);
  reg [WIDTH-1:0] left_reg;

  assign o_pulse = (left_reg != {WIDTH{1'b0}});

  // (R12) quarter bit time
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      left_reg <= {WIDTH{1'b0}};
    end else if (i_start) begin
      left_reg <= {2'b00, i_bit_time[WIDTH-1:2]};
    end else if (i_tick && o_pulse) begin
      left_reg <= left_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ---- rtl/single_wire_host_error_bittime.v ----
// Purpose: error capture, interrupt enables and bit time for the single-wire host
// Assumes: event inputs are one-cycle pulses from the frame engine
// Notes: registers are byte wide; unmapped reads return zero
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "swire_defines.vh"
module single_wire_host_error_bittime #(
  parameter WIDTH = 16
) (
  input wire i_mclk,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_frame_start,
  input wire i_frame_done,
  input wire i_ready,
  input wire i_rx_overflow,
  input wire i_byte_needed,
  input wire i_tx_empty,
  input wire i_tx_write,
  input wire i_tx_full,
  input wire i_drive_level,
  input wire i_bus_level,
  input wire i_sample,
  input wire i_check_valid,
  input wire [7:0] i_check_own,
  input wire [7:0] i_check_target,
  input wire i_frame_begin_flag,
  input wire i_frame_end_flag,
  input wire i_rx_fifo_full,
  input wire i_tx_fifo_empty,
  output wire o_error_summary,
  output wire o_irq,
  output wire o_tx_accept,
  output wire o_force_checksum,
  output wire o_idle,
  output wire o_frame_end,
  output wire o_transmit_enable_flag,
  output wire o_core_tick,
  output wire o_negotiation_pulse,
  output wire [WIDTH-1:0] o_negotiation_bit_time
);
  reg [7:0] error_reg;
  reg [7:0] error_next;
  reg [2:0] ien_frame_reg;
  reg [2:0] ien_fifo_reg;
  reg [7:0] obt_lo_reg;
  reg [7:0] obt_hi_reg;
  reg [WIDTH-1:0] baud_reg;
  reg busy_reg;
  reg stuck_reg;
  reg [7:0] wmask;
  wire ack_clear;
  wire clk_loss;
  wire bus_mismatch;
  wire [7:0] set_vec;

  // (R11) bit time from two bytes
  assign o_negotiation_bit_time = {obt_hi_reg, obt_lo_reg};

  // (R16) core clock from main clock
  core_clock_divider #(
    .WIDTH(WIDTH)
  ) u_div (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_divisor(baud_reg),
    .o_tick(o_core_tick)
  );

  // (R13) bit is four pulse widths
  negotiation_pulse #(
    .WIDTH(WIDTH)
  ) u_pulse (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_tick(o_core_tick),
    .i_start(i_frame_start),
    .i_bit_time(o_negotiation_bit_time),
    .o_pulse(o_negotiation_pulse)
  );

  // (R1) ready drop mid-frame
  assign clk_loss = busy_reg && !i_ready;
  // (R5) read-back mismatch
  assign bus_mismatch = busy_reg && i_sample && (i_drive_level != i_bus_level);

  // event vector; clock loss also raises the checksum error
  assign set_vec[`BIT_CLKLOSS] = clk_loss;
  // (R2) receive overflow
  assign set_vec[`BIT_RXOV] = i_rx_overflow;
  // (R3) transmit underrun
  assign set_vec[`BIT_TXUR] = i_byte_needed && i_tx_empty;
  // (R4) write to full buffer
  assign set_vec[`BIT_TXOV] = i_tx_write && i_tx_full;
  assign set_vec[3:2] = 2'b00;
  // (R6) stuck high reports contention
  assign set_vec[`BIT_BUSCON] = bus_mismatch || stuck_reg;
  // (R8) check value compare
  assign set_vec[`BIT_CHKERR] = (i_check_valid && (i_check_own != i_check_target)) || clk_loss;

  // (R4) full buffer drops the byte
  assign o_tx_accept = i_tx_write && !i_tx_full;
  assign o_force_checksum = clk_loss;
  assign ack_clear = i_wr && (i_addr == `ADDR_ERROR);

  // (R20) write one clears, set wins
  always @* begin
    wmask = ack_clear ? i_wdata : 8'h00;
    error_next = ((error_reg & ~wmask) | set_vec) & `ERROR_MASK;
  end

  // (R18) summary while any flag held
  assign o_error_summary = (error_reg != 8'h00);

  // (R9) frame interrupt gating
  // (R10) fifo interrupt gating
  assign o_irq = (ien_frame_reg[`BIT_EN_ERR] && o_error_summary)
    || (ien_frame_reg[`BIT_EN_END] && i_frame_end_flag)
    || (ien_frame_reg[`BIT_EN_BEGIN] && i_frame_begin_flag)
    || (ien_fifo_reg[`BIT_EN_RXFULL] && i_rx_fifo_full)
    || (ien_fifo_reg[`BIT_EN_TXEMPTY] && i_tx_fifo_empty);

  // (R19) idle outside a frame
  // (R6) stuck bus never idles again until reset
  assign o_idle = !busy_reg && !stuck_reg;
  assign o_frame_end = i_frame_done && !stuck_reg;
  assign o_transmit_enable_flag = busy_reg || stuck_reg;

  // frame tracking and stuck-high detection; stuck only leaves by reset
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_reg <= 1'b0;
      stuck_reg <= 1'b0;
    end else begin
      if (i_frame_start) begin
        busy_reg <= 1'b1;
      end else if (i_frame_done && !stuck_reg) begin
        busy_reg <= 1'b0;
      end
      // (R6) high when driven low
      if (busy_reg && i_sample && !i_drive_level && i_bus_level) begin
        stuck_reg <= 1'b1;
      end
    end
  end

  // register writes; bit time writes rely on software waiting for idle
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      error_reg <= 8'h00;
      ien_frame_reg <= 3'h0;
      ien_fifo_reg <= 3'h0;
      // byte-wide reset values keep the low and high halves of the bit time exact
      obt_lo_reg <= `OBT_LO_RESET;
      obt_hi_reg <= `OBT_HI_RESET;
      baud_reg <= `BAUD_RESET;
    end else begin
      error_reg <= error_next;
      if (i_wr) begin
        if (i_addr == `ADDR_IEN_FRAME) begin
          ien_frame_reg <= i_wdata[2:0];
        end else if (i_addr == `ADDR_IEN_FIFO) begin
          ien_fifo_reg <= i_wdata[2:0] & 3'h6;
        end else if (i_addr == `ADDR_OBT_LO) begin
          obt_lo_reg <= i_wdata;
        end else if (i_addr == `ADDR_OBT_HI) begin
          obt_hi_reg <= i_wdata;
        end else if (i_addr == `ADDR_BAUD) begin
          baud_reg <= {{(WIDTH-8){1'b0}}, i_wdata};
        end
      end
    end
  end

  // read data stand one cycle after the strobe only
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == `ADDR_ERROR) begin
      o_rdata <= error_reg;
    end else if (i_addr == `ADDR_IEN_FRAME) begin
      o_rdata <= {5'h00, ien_frame_reg};
    end else if (i_addr == `ADDR_IEN_FIFO) begin
      o_rdata <= {5'h00, ien_fifo_reg};
    end else if (i_addr == `ADDR_OBT_LO) begin
      o_rdata <= obt_lo_reg;
    end else if (i_addr == `ADDR_OBT_HI) begin
      o_rdata <= obt_hi_reg;
    end else if (i_addr == `ADDR_BAUD) begin
      o_rdata <= baud_reg[7:0];
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// ---- rtl/swire_defines.vh ----
// Purpose: constants for the single-wire error, enable and bit time block
// Assumes: byte-wide registers on a plain strobe port, index*4 byte addresses
// Notes: guard against double inclusion
//
// Summary of operation
// (R1) ready loss mid-frame sets bit 7, frame still ends, checksum error too
// (R2) receive buffer overflow sets bit 6, frame ends normally
// (R3) byte needed but transmit buffer empty sets bit 5
// (R4) write to full transmit buffer is dropped and sets bit 4
// (R5) read-back level differing from driven level sets bit 1
// (R6) bus stuck high after start: bit 1 only, no idle, no frame end
// (R7) software must reset the controller after a stuck-high fault
// (R8) own check value differing from target's sets bit 0, frame continues
// (R9) enable 1: bit 2 error, bit 1 frame end, bit 0 frame begin
// (R10) enable 2: bit 2 receive full, bit 1 transmit empty
// (R11) 16-bit bit time from low and high bytes sets negotiation pulse
// (R12) negotiation high pulse lasts bit time over four core clock periods
// (R13) one bit spans four pulse widths, the full bit time count
// (R14) software writes bit time bytes only while idle
// (R15) software keeps bit time within 0010h to FFFFh
// (R16) core bit clock derives from the main system clock
// (R17) core bit clock is main clock divided by the 16-bit baud value; only the low byte is writable, the upper byte stays zero
// (R18) error summary stays high while any captured error is set
// (R19) idle drops during a frame and returns after setup time; the code raises idle once frame done clears busy
// (R20) error flags held until written one, all cleared on reset
`ifndef SWIRE_DEFINES_VH
`define SWIRE_DEFINES_VH
`define ADDR_ERROR 8'h14
`define ADDR_IEN_FRAME 8'h18
`define ADDR_IEN_FIFO 8'h1C
`define ADDR_OBT_LO 8'h20
`define ADDR_OBT_HI 8'h24
`define ADDR_BAUD 8'h30
`define BIT_CLKLOSS 7
`define BIT_RXOV 6
`define BIT_TXUR 5
`define BIT_TXOV 4
`define BIT_BUSCON 1
`define BIT_CHKERR 0
`define BIT_EN_ERR 2
`define BIT_EN_END 1
`define BIT_EN_BEGIN 0
`define BIT_EN_RXFULL 2
`define BIT_EN_TXEMPTY 1
`define ERROR_MASK 8'hF3
`define IEN_FRAME_MASK 8'h07
`define IEN_FIFO_MASK 8'h06
`define OBT_RESET 16'h0016
`define OBT_LO_RESET 8'h16
`define OBT_HI_RESET 8'h00
`define BAUD_RESET 16'h0001
`endif

// ---- verification/swire_props.sv ----
// Purpose: port assertions for the error and bit time block
// Assumes: one clock, async active-low reset
// Notes: bound to the block at the foot of this file
`timescale 1ns/100ps
module swire_props (
  input wire i_mclk,
  input wire i_reset_n,
  input wire [7:0] i_addr,
  input wire i_wr,
  input wire i_frame_start,
  input wire i_frame_done,
  input wire i_ready,
  input wire i_rx_overflow,
  input wire i_byte_needed,
  input wire i_tx_empty,
  input wire i_tx_write,
  input wire i_tx_full,
  input wire i_check_valid,
  input wire [7:0] i_check_own,
  input wire [7:0] i_check_target,
  input wire o_error_summary,
  input wire o_tx_accept,
  input wire o_force_checksum,
  input wire o_idle,
  input wire o_frame_end
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // each flag but contention is checked to show in the summary one cycle after its cause
  sequence s_flag;
    o_error_summary;
  endsequence
  chk_tx_over: assert property (i_tx_write && i_tx_full |-> !o_tx_accept ##1 s_flag)
    else $error("full buffer write not dropped");
  chk_rx_over: assert property (i_rx_overflow |=> s_flag)
    else $error("receive overflow lost");
  chk_tx_under: assert property (i_byte_needed && i_tx_empty |=> s_flag)
    else $error("underrun lost");
  chk_check_err: assert property (i_check_valid && i_check_own != i_check_target |=> s_flag)
    else $error("check mismatch lost");
  chk_ready_loss: assert property (o_force_checksum |-> !i_ready ##1 s_flag)
    else $error("ready loss mishandled");
  // only a write to the error register may clear the summary
  chk_err_hold: assert property (s_flag and !(i_wr && i_addr == 8'h14) |=> s_flag)
    else $error("error flag lost");
  chk_idle_drop: assert property (i_frame_start |=> !o_idle)
    else $error("idle stayed high");
  chk_end_gate: assert property (o_frame_end |-> i_frame_done)
    else $error("frame end without done");
endmodule
bind single_wire_host_error_bittime swire_props swire_props_i (.*);

// ---- verification/tb_single_wire_host_error_bittime.sv ----
// Purpose: register, event and bit time checks of the error block
// Assumes: event inputs are one-cycle pulses, baud 1 ticks every cycle
// Notes: the stuck-bus case ends with a reset
`timescale 1ns/100ps
module tb_single_wire_host_error_bittime;
  reg i_mclk = 1'h0, i_reset_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
  reg i_drive_level = 1'h0, flip = 1'h0, stuck = 1'h0, drop = 1'h0;
  reg [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_check_own = 8'h5A, i_check_target = 8'hA5;
  reg [6:0] ev = 7'h00;
  reg [5:0] lv = 6'h00;
  reg [15:0] np, nt;
  wire i_frame_done, i_frame_start, i_sample, i_check_valid, i_tx_write, i_byte_needed;
  wire i_rx_overflow, i_tx_fifo_empty, i_rx_fifo_full, i_frame_end_flag, i_frame_begin_flag;
  wire i_tx_full, i_tx_empty, i_bus_level, i_ready, o_error_summary, o_irq, o_tx_accept;
  wire o_force_checksum, o_idle, o_frame_end, o_transmit_enable_flag, o_core_tick;
  wire o_negotiation_pulse;
  wire [7:0] o_rdata;
  wire [15:0] o_negotiation_bit_time;
  integer fails = 0, cmp_count = 0, cyc = 0, w, i;
  logic [7:0] em [4] = '{8'h40, 8'h20, 8'h10, 8'h01};
  // event pulses packed so one task drives them all, levels packed into one vector set directly
  assign {i_frame_done, i_frame_start, i_sample, i_check_valid} = ev[6:3];
  assign {i_tx_write, i_byte_needed, i_rx_overflow} = ev[2:0];
  assign {i_tx_fifo_empty, i_rx_fifo_full, i_frame_end_flag} = lv[5:3];
  assign {i_frame_begin_flag, i_tx_full, i_tx_empty} = lv[2:0];
  thermal_target_model thermal_target_model_i (.i_drive_level(i_drive_level), .i_flip(flip),
    .i_stuck(stuck), .i_drop(drop), .o_bus_level(i_bus_level), .o_ready(i_ready));
  single_wire_host_error_bittime single_wire_host_error_bittime_i (.*);
  initial forever #2 i_mclk = ~i_mclk;
  // cut a hang short well past the expected run
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      results;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_mclk);
    i_wr <= 1'h0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    #1 chk(o_rdata, e);
  endtask
  task fire(input [6:0] k);
    @(posedge i_mclk);
    ev <= k;
    @(posedge i_mclk);
    ev <= 7'h00;
  endtask
  task rst;
    i_reset_n <= 1'h0;
    repeat (5) @(posedge i_mclk);
    i_reset_n <= 1'h1;
  endtask
  // counts pulse and tick cycles over a fixed window
  task span;
    np = 16'h0000;
    nt = 16'h0000;
    repeat (240) begin
      #1 np = np + (o_negotiation_pulse === 1'h1);
      nt = nt + (o_core_tick === 1'h1);
      @(posedge i_mclk);
    end
  endtask
  task results;
    $display("fails %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst;
    rd(8'h14, 8'h00);
    rd(8'h20, 8'h16);
    rd(8'h30, 8'h01);
    rd(8'h40, 8'h00);
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'h07);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h06);
    // each event sets its own flag, a write of ones clears it
    lv <= 6'h03;
    for (i = 0; i < 4; i++) begin
      fire(7'h01 << i);
      rd(8'h14, em[i]);
      wr(8'h14, 8'hFF);
      rd(8'h14, 8'h00);
    end
    fire(7'h01);
    #1 chk(o_irq, 1'h1);
    wr(8'h18, 8'h00);
    #1 chk(o_irq, 1'h0);
    lv <= 6'h13;
    #1 chk(o_irq, 1'h1);
    lv <= 6'h0B;
    #1 chk(o_irq, 1'h0);
    wr(8'h18, 8'h03);
    lv <= 6'h07;
    #1 chk(o_irq, 1'h1);
    wr(8'h18, 8'h00);
    lv <= 6'h03;
    wr(8'h14, 8'hFF);
    // contention then ready loss inside one frame, which still completes
    fire(7'h20);
    #1 chk(o_idle, 1'h0);
    i_drive_level <= 1'h1;
    flip <= 1'h1;
    fire(7'h10);
    flip <= 1'h0;
    drop <= 1'h1;
    fire(7'h40);
    drop <= 1'h0;
    rd(8'h14, 8'h83);
    for (w = 0; w < 500 && o_idle !== 1'h1; w++) @(posedge i_mclk);
    chk(o_idle, 1'h1);
    wr(8'h14, 8'hFF);
    // high byte first: 0x0140 gives an 80-tick pulse
    wr(8'h24, 8'h01);
    wr(8'h20, 8'h40);
    #1 chk(o_negotiation_bit_time, 16'h0140);
    fire(7'h20);
    span;
    chk(np, 16'h0050);
    chk(nt, 16'h00F0);
    fire(7'h40);
    wr(8'h30, 8'h03);
    span;
    chk(nt, 16'h0050);
    wr(8'h30, 8'h01);
    for (w = 0; w < 500 && o_idle !== 1'h1; w++) @(posedge i_mclk);
    // wire stuck high after a start: contention flag only
    i_drive_level <= 1'h0;
    stuck <= 1'h1;
    fire(7'h20);
    fire(7'h10);
    fire(7'h40);
    rd(8'h14, 8'h02);
    chk(o_idle, 1'h0);
    chk(o_transmit_enable_flag, 1'h1);
    stuck <= 1'h0;
    rst;
    rd(8'h14, 8'h00);
    #1 chk(o_idle, 1'h1);
    results;
  end
endmodule

// ---- verification/thermal_target_model.sv ----
// Purpose: processor target at the far end of the single wire
// Assumes: read-back follows the host drive unless a fault is commanded
// Notes: faults appear only when the bench asks for them
`timescale 1ns/100ps
module thermal_target_model (
  input wire i_drive_level,
  input wire i_flip,
  input wire i_stuck,
  input wire i_drop,
  output wire o_bus_level,
  output wire o_ready
);
  // a stuck wire reads high whatever the host drives
  assign o_bus_level = i_stuck | (i_drive_level ^ i_flip);
  assign o_ready = !i_drop; // ready lost only on command
endmodule
